// >>> pll_lock_detect_test_mode.sv
`timescale 1ns/100ps
// How it works
// - A feedback edge too far behind the reference edge is a phase error.
// - When locked, four back-to-back erroneous feedback cycles drop lock low.
// - When unlocked, 32 back-to-back clean feedback cycles raise lock; errors restart.
// - Missing feedback activity after lock drops lock when the watchdog expires.
// - Watchdog timeout counts ticks of a divided reference clock.
// - Mode strap at middle level enters factory test mode.
// - Test mode bypasses the PLL, reference level becomes internal clock.
// - Test mode forces the feedback input low internally.
// - Test mode keeps dividers and phase logic working, ignores bank disables except bank two disable's test reset.
// - Mode passing through middle level acts as test mode meanwhile.
// - In test mode bank two disable high requests reset, outputs high-Z.
// - State machines take deterministic state after five reference rising edges.
// - Deterministic state depends on divide, skew and frequency selections.
// - High-Z and reset state hold until bank two disable falls or the mode strap leaves middle level.
// - Mode low and disable high stops a bank low on a falling edge.
module pll_lock_detect_test_mode #(
    parameter int NUM_BANKS = 2,
    parameter int GOOD_W = 6
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // APB slave
    input wire clk_supervise_pkg::apb_req_t apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    // Clock pins
    input wire logic ref_clk_in,
    input wire logic feedback_clock_in,
    input wire logic pll_clk_in,
    // Static straps
    input wire logic [1:0] mode_in,
    input wire logic [1:0] bank_disable_inputs,
    input wire clk_supervise_pkg::clk_config_t cfg_in,
    // Outputs
    output logic lock_out,
    output logic pll_bypass,
    output logic internal_clk,
    output logic [1:0] bank_clk_out,
    output logic [1:0] bank_clk_oe
);
    import clk_supervise_pkg::*;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    localparam int PIN_W = 3 + 2 + 2 + $bits(clk_config_t);
    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_s1_reg;
    logic [PIN_W-1:0] pin_s2_reg;
    logic [PIN_W-1:0] pin_s3_reg;
    logic [PIN_W-1:0] pin_reg;

    assign pin_raw = {ref_clk_in, feedback_clock_in, pll_clk_in, mode_in,
                      bank_disable_inputs, cfg_in};

    // A change counts only once stages two and three agree
    genvar gp;
    generate
        for (gp = 0; gp < PIN_W; gp++) begin : g_sync
            always_ff @(posedge clk) begin
                if (rst) begin
                    pin_s1_reg[gp] <= 1'b0;
                    pin_s2_reg[gp] <= 1'b0;
                    pin_s3_reg[gp] <= 1'b0;
                    pin_reg[gp] <= 1'b0;
                end else begin
                    pin_s1_reg[gp] <= pin_raw[gp];
                    pin_s2_reg[gp] <= pin_s1_reg[gp];
                    pin_s3_reg[gp] <= pin_s2_reg[gp];
                    if (pin_s2_reg[gp] == pin_s3_reg[gp]) begin
                        pin_reg[gp] <= pin_s3_reg[gp];
                    end
                end
            end
        end
    endgenerate

    clk_config_t cfg;
    logic ref_lvl;
    logic fb_pin;
    logic pll_lvl;
    logic [1:0] mode_lvl;
    logic [1:0] dis_lvl;
    assign {ref_lvl, fb_pin, pll_lvl, mode_lvl, dis_lvl, cfg} = pin_reg;

    // ************************************************************
    // Mode decode
    // ************************************************************
    logic test_mode;
    logic fb_lvl;
    logic int_lvl;
    // Anything not cleanly low or high counts as middle, so a strap in transit is test
    assign test_mode = (mode_lvl != LVL_LOW) && (mode_lvl != LVL_HIGH);
    assign fb_lvl = test_mode ? 1'b0 : fb_pin;
    assign int_lvl = test_mode ? ref_lvl : pll_lvl;

    // Edge detection on filtered levels
    logic ref_q_reg;
    logic fb_q_reg;
    logic int_q_reg;
    logic ref_rise;
    logic fb_rise;
    logic int_rise;
    always_ff @(posedge clk) begin
        if (rst) begin
            ref_q_reg <= 1'b0;
            fb_q_reg <= 1'b0;
            int_q_reg <= 1'b0;
        end else begin
            ref_q_reg <= ref_lvl;
            fb_q_reg <= fb_lvl;
            int_q_reg <= int_lvl;
        end
    end
    assign ref_rise = ref_lvl & ~ref_q_reg;
    assign fb_rise = fb_lvl & ~fb_q_reg;
    assign int_rise = int_lvl & ~int_q_reg;

    // ************************************************************
    // Registers
    // ************************************************************
    logic ctrl_reg;
    logic [7:0] phase_limit_reg;
    logic [7:0] wdog_limit_reg;
    logic [3:0] ref_div_reg;
    logic [IRQ_BITS-1:0] irq_stat_reg;
    logic [IRQ_BITS-1:0] irq_mask_reg;
    logic [IRQ_BITS-1:0] irq_event;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic [31:0] rd_mux;
    logic [31:0] status_word;

    assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite;
    assign rd_en = apb_req.psel & apb_req.penable & ~apb_req.pwrite;
    assign addr_ok = (apb_req.paddr == ADDR_CTRL) || (apb_req.paddr == ADDR_PHASE_LIMIT)
                  || (apb_req.paddr == ADDR_WDOG_LIMIT) || (apb_req.paddr == ADDR_STATUS)
                  || (apb_req.paddr == ADDR_IRQ_STAT) || (apb_req.paddr == ADDR_IRQ_MASK);
    assign pready = 1'b1; // Zero wait states
    assign pslverr = apb_req.psel & apb_req.penable & ~addr_ok;
    assign irq = |(irq_stat_reg & irq_mask_reg);

    // Config writes; ref divider packed into the watchdog register
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_reg <= CTRL_RST;
            phase_limit_reg <= PHASE_LIMIT_CYC;
            wdog_limit_reg <= WDOG_LIMIT_RST;
            ref_div_reg <= REF_DIV_RST;
            irq_mask_reg <= '0;
        end else if (wr_en) begin
            if (apb_req.paddr == ADDR_CTRL) begin
                ctrl_reg <= apb_req.pwdata[0];
            end
            if (apb_req.paddr == ADDR_PHASE_LIMIT) begin
                phase_limit_reg <= apb_req.pwdata[7:0];
            end
            if (apb_req.paddr == ADDR_WDOG_LIMIT) begin
                wdog_limit_reg <= apb_req.pwdata[7:0];
                ref_div_reg <= apb_req.pwdata[11:8];
            end
            if (apb_req.paddr == ADDR_IRQ_MASK) begin
                irq_mask_reg <= apb_req.pwdata[IRQ_BITS-1:0];
            end
        end
    end

    // Sticky events; a new event beats a write-one clear in the same cycle
    logic [IRQ_BITS-1:0] irq_clr;
    assign irq_clr = (wr_en && apb_req.paddr == ADDR_IRQ_STAT) ?
                     apb_req.pwdata[IRQ_BITS-1:0] : '0;
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_stat_reg <= '0;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_event;
        end
    end

    // Read data is registered so the bus sees flops
    always_comb begin
        rd_mux = 32'h0;
        unique case (apb_req.paddr)
            ADDR_CTRL: rd_mux = {31'h0, ctrl_reg};
            ADDR_PHASE_LIMIT: rd_mux = {24'h0, phase_limit_reg};
            ADDR_WDOG_LIMIT: rd_mux = {20'h0, ref_div_reg, wdog_limit_reg};
            ADDR_STATUS: rd_mux = status_word;
            ADDR_IRQ_STAT: rd_mux = {28'h0, irq_stat_reg};
            ADDR_IRQ_MASK: rd_mux = {28'h0, irq_mask_reg};
            default: rd_mux = 32'h0;
        endcase
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata <= 32'h0;
        end else if (apb_req.psel & ~apb_req.penable & ~apb_req.pwrite) begin
            prdata <= rd_mux;
        end
    end

    // ************************************************************
    // Test reset sequencer
    // ************************************************************
    typedef enum logic [1:0] {TR_IDLE, TR_COUNT, TR_HOLD} test_rst_t;
    test_rst_t tr_reg;
    test_rst_t tr_next;
    logic [2:0] tr_edges_reg;
    logic tr_active;
    logic tr_load;

    always_comb begin
        tr_next = tr_reg;
        unique case (tr_reg)
            TR_IDLE: if (test_mode && dis_lvl[1]) tr_next = TR_COUNT;
            TR_COUNT: begin
                if (!test_mode || !dis_lvl[1]) begin
                    tr_next = TR_IDLE;
                end else if (ref_rise && tr_edges_reg == TEST_RESET_EDGES - 3'h1) begin
                    tr_next = TR_HOLD;
                end
            end
            TR_HOLD: if (!test_mode || !dis_lvl[1]) tr_next = TR_IDLE;
        endcase
    end
    assign tr_active = (tr_reg != TR_IDLE);
    assign tr_load = (tr_reg == TR_COUNT) && (tr_next == TR_HOLD);

    always_ff @(posedge clk) begin
        if (rst) begin
            tr_reg <= TR_IDLE;
            tr_edges_reg <= 3'h0;
        end else begin
            tr_reg <= tr_next;
            if (tr_reg != TR_COUNT) begin
                tr_edges_reg <= 3'h0;
            end else if (ref_rise) begin
                tr_edges_reg <= tr_edges_reg + 3'h1;
            end
        end
    end

    // ************************************************************
    // Phase error and lock detector
    // ************************************************************
    typedef enum logic {LK_OUT, LK_IN} lock_t;
    lock_t lock_reg;
    logic [7:0] since_ref_reg;
    logic [2:0] err_run_reg;
    logic [GOOD_W-1:0] good_run_reg;
    logic phase_err;
    logic wdog_expire;
    logic lock_gain;
    logic lock_lose;

    // Late feedback edge relative to the last reference edge
    assign phase_err = !ref_rise && (since_ref_reg > phase_limit_reg);
    assign lock_gain = (lock_reg == LK_OUT) && fb_rise && !phase_err
                    && (good_run_reg == GOOD_W'(LOCK_GOOD_COUNT - 6'h1));
    assign lock_lose = (lock_reg == LK_IN) && ((fb_rise && phase_err
                    && err_run_reg >= LOSS_ERR_COUNT - 3'h1) || wdog_expire);

    always_ff @(posedge clk) begin
        if (rst) begin
            since_ref_reg <= 8'h0;
        end else if (ref_rise) begin
            since_ref_reg <= 8'h0;
        end else if (since_ref_reg != 8'hFF) begin
            since_ref_reg <= since_ref_reg + 8'h1;
        end
    end

    // Lock starts low; a disabled detector or test reset keeps it low
    always_ff @(posedge clk) begin
        if (rst || !ctrl_reg || tr_active) begin
            lock_reg <= LK_OUT;
            err_run_reg <= 3'h0;
            good_run_reg <= '0;
        end else begin
            if (lock_gain) begin
                lock_reg <= LK_IN;
            end else if (lock_lose) begin
                lock_reg <= LK_OUT;
            end
            if (fb_rise && phase_err) begin
                good_run_reg <= '0;
                if (err_run_reg != 3'h7) begin
                    err_run_reg <= err_run_reg + 3'h1;
                end
            end else if (fb_rise) begin
                err_run_reg <= 3'h0;
                if (lock_reg == LK_OUT && !lock_gain) begin
                    good_run_reg <= good_run_reg + GOOD_W'(1);
                end else begin
                    good_run_reg <= '0;
                end
            end
            if (lock_lose) begin
                good_run_reg <= '0;
            end
        end
    end
    assign lock_out = (lock_reg == LK_IN);

    // ************************************************************
    // Feedback watchdog on divided reference
    // ************************************************************
    logic [3:0] ref_pre_reg;
    logic [7:0] wdog_reg;
    logic ref_tick;
    // Reference timing survives a dead feedback clock
    assign ref_tick = ref_rise && (ref_pre_reg >= ref_div_reg);
    assign wdog_expire = ref_tick && (wdog_reg >= wdog_limit_reg - 8'h1);

    always_ff @(posedge clk) begin
        if (rst) begin
            ref_pre_reg <= 4'h0;
            wdog_reg <= 8'h0;
        end else begin
            if (ref_tick) begin
                ref_pre_reg <= 4'h0;
            end else if (ref_rise) begin
                ref_pre_reg <= ref_pre_reg + 4'h1;
            end
            if (fb_rise) begin
                wdog_reg <= 8'h0;
            end else if (ref_tick && wdog_reg != 8'hFF) begin
                wdog_reg <= wdog_reg + 8'h1;
            end
        end
    end

    assign irq_event = {tr_load, wdog_expire & (lock_reg == LK_IN), lock_lose, lock_gain};
    assign status_word = {28'h0, (tr_reg == TR_HOLD), tr_active, test_mode, lock_out};

    // ************************************************************
    // Bank dividers and output gating
    // ************************************************************
    // Ratio table for the nine three-level divide codes
    function automatic logic [3:0] div_ratio(input logic [3:0] sel);
        logic [3:0] r;
        r = 4'h1;
        unique case (sel)
            4'h0: r = 4'h1;
            4'h1: r = 4'h2;
            4'h2: r = 4'h3;
            4'h3: r = 4'h4;
            4'h4: r = 4'h5;
            4'h5: r = 4'h6;
            4'h6: r = 4'h8;
            4'h7: r = 4'hA;
            4'h8: r = 4'hC;
            default: r = 4'h1;
        endcase
        return r;
    endfunction

    logic [NUM_BANKS-1:0][3:0] div_sel;
    logic [NUM_BANKS-1:0][3:0] skew_sel;
    assign div_sel = {cfg.div_sel_b2, cfg.div_sel_b1};
    assign skew_sel = {cfg.skew_sel_b2, cfg.skew_sel_b1};
    assign pll_bypass = test_mode;
    assign internal_clk = int_q_reg;

    genvar gb;
    generate
        for (gb = 0; gb < NUM_BANKS; gb++) begin : g_bank
            logic [3:0] ratio;
            logic [4:0] seed_sum;
            logic [3:0] seed;
            logic [4:0] phase_reg;
            logic out_reg;
            logic hold_reg;
            logic tick;
            logic holdoff_req;
            logic hiz_req;
            assign ratio = div_ratio(div_sel[gb]);
            // Reset phase mixes divide, skew and range so every setup is repeatable
            assign seed_sum = {1'b0, skew_sel[gb]} + {3'h0, cfg.fs_sel};
            assign seed = 4'(seed_sum % {1'b0, ratio});
            assign tick = int_rise;
            // Bank disables are ignored in test mode except through test reset
            assign holdoff_req = !test_mode && (mode_lvl == LVL_LOW) && dis_lvl[gb];
            assign hiz_req = tr_active || (!test_mode && mode_lvl == LVL_HIGH && dis_lvl[gb]);

            // Twice-ratio phase counter gives a square wave at int / (2 x ratio)
            always_ff @(posedge clk) begin
                if (rst) begin
                    phase_reg <= 5'h0;
                    out_reg <= 1'b0;
                end else if (tr_active) begin
                    if (tr_load || tr_reg == TR_HOLD) begin
                        phase_reg <= {1'b0, seed};
                        out_reg <= 1'b0;
                    end
                end else if (tick) begin
                    if (phase_reg >= {ratio, 1'b0} - 5'h1) begin
                        phase_reg <= 5'h0;
                    end else begin
                        phase_reg <= phase_reg + 5'h1;
                    end
                    out_reg <= (phase_reg + 5'h1 >= {1'b0, ratio}) &&
                               (phase_reg + 5'h1 < {ratio, 1'b0});
                end
            end

            // Hold-off engages only while the clock is already low
            always_ff @(posedge clk) begin
                if (rst || !holdoff_req) begin
                    hold_reg <= 1'b0;
                end else if (!out_reg) begin
                    hold_reg <= 1'b1;
                end
            end

            assign bank_clk_out[gb] = out_reg & ~hold_reg & ~(holdoff_req & ~out_reg);
            assign bank_clk_oe[gb] = ~hiz_req;
        end
    endgenerate

endmodule

// >>> clk_supervise_pkg.sv
package clk_supervise_pkg;

    // ************************************************************
    // Three-level strap encoding
    // ************************************************************
    localparam logic [1:0] LVL_LOW = 2'h0;
    localparam logic [1:0] LVL_MID = 2'h1;
    localparam logic [1:0] LVL_HIGH = 2'h2;

    // ************************************************************
    // Register map (byte addresses)
    // ************************************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_PHASE_LIMIT = 8'h04;
    localparam logic [7:0] ADDR_WDOG_LIMIT = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;

    // Interrupt bit positions
    localparam int IRQ_LOCK_GAINED = 0;
    localparam int IRQ_LOCK_LOST = 1;
    localparam int IRQ_WDOG = 2;
    localparam int IRQ_TEST_RESET = 3;
    localparam int IRQ_BITS = 4;

    // ************************************************************
    // Timing and counts
    // ************************************************************
    localparam int CLK_PERIOD_NS = 40;
    localparam int PHASE_LIMIT_NS = 120;
    localparam logic [7:0] PHASE_LIMIT_CYC = 8'(PHASE_LIMIT_NS / CLK_PERIOD_NS);
    localparam logic [2:0] LOSS_ERR_COUNT = 3'h4;
    localparam logic [5:0] LOCK_GOOD_COUNT = 6'h20;
    localparam logic [2:0] TEST_RESET_EDGES = 3'h5;
    localparam logic [7:0] WDOG_LIMIT_RST = 8'h08;
    localparam logic [3:0] REF_DIV_RST = 4'hF;
    localparam logic CTRL_RST = 1'h1;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic [1:0] fs_sel;
        logic [3:0] div_sel_b1;
        logic [3:0] div_sel_b2;
        logic [3:0] skew_sel_b1;
        logic [3:0] skew_sel_b2;
    } clk_config_t;

    typedef struct packed {
        logic [7:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } apb_req_t;

endpackage

// >>> board_clk_model.sv
`timescale 1ns/100ps
module board_clk_model (
    // Clock
    input wire logic clk,
    // Bench controls
    input wire logic fb_run,
    input wire logic fb_late,
    // Clock pins
    output logic ref_clk_in,
    output logic feedback_clock_in,
    output logic pll_clk_in
);
    logic [3:0] phase_reg = 4'h0;
    logic run_reg = 1'b0;
    logic late_reg = 1'b0;

    // Controls change only at the period boundary, so no runt pulse appears
    always_ff @(posedge clk) begin
        phase_reg <= phase_reg + 4'h1;
        if (phase_reg == 4'hF) begin
            run_reg <= fb_run;
            late_reg <= fb_late;
        end
    end

    // Reference never pauses; a late feedback lags half a period
    assign ref_clk_in = ~phase_reg[3];
    assign feedback_clock_in = run_reg & (phase_reg[3] ^ ~late_reg);
    assign pll_clk_in = phase_reg[2];
endmodule

// >>> pll_lock_checker_asserts.sv
`timescale 1ns/100ps
module pll_lock_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Pins
    input wire logic ref_clk_in,
    input wire logic feedback_clock_in,
    input wire logic [1:0] mode_in,
    input wire logic [1:0] bank_disable_inputs,
    input wire logic lock_out,
    input wire logic pll_bypass,
    input wire logic internal_clk,
    input wire logic [1:0] bank_clk_out,
    input wire logic [1:0] bank_clk_oe
);
    import clk_supervise_pkg::*;
    logic [9:0] low_cnt;
    logic [7:0] ref_ticks;
    logic ref_prev;
    logic fb_prev;
    wire ref_rise = ref_clk_in & ~ref_prev;

    // Saturating counters, so a long idle never wraps into a false pass
    always_ff @(posedge clk) begin
        ref_prev <= ref_clk_in;
        fb_prev <= feedback_clock_in;
        if (rst || lock_out) begin
            low_cnt <= 10'h000;
        end else if (!(&low_cnt)) begin
            low_cnt <= low_cnt + 10'h001;
        end
        if (rst || feedback_clock_in != fb_prev) begin
            ref_ticks <= 8'h00;
        end else if (ref_rise && !(&ref_ticks)) begin
            ref_ticks <= ref_ticks + 8'h01;
        end
    end

    default clocking dc @(posedge clk);
    endclocking
    default disable iff (rst);

    // ****
    // Properties
    // ****
    a_lock_reset: assert property ($fell(rst) |-> !lock_out)
        else $error("lock high after reset");
    a_lock_min: assert property ($rose(lock_out) |-> low_cnt >= 10'h0BA)
        else $error("lock rose too early");
    a_lock_test: assert property ($rose(lock_out) |-> !pll_bypass)
        else $error("lock rose in test mode");
    a_fb_loss: assert property (ref_ticks >= 8'h96 |-> !lock_out)
        else $error("lock held without feedback");
    a_bypass_mid: assert property ((mode_in == LVL_MID)[*6] |-> pll_bypass)
        else $error("no bypass at mid mode");
    a_bypass_low: assert property ((mode_in == LVL_LOW)[*6] |-> !pll_bypass)
        else $error("bypass at low mode");
    a_test_hiz: assert property ((mode_in == LVL_MID && bank_disable_inputs[1])[*7]
        |-> bank_clk_oe == 2'h0) else $error("outputs driven in test reset");
    a_test_release: assert property ((mode_in == LVL_MID && !bank_disable_inputs[1])[*8]
        |-> bank_clk_oe == 2'h3) else $error("outputs off after test reset");
    a_int_clk: assert property ((mode_in == LVL_MID && $stable(ref_clk_in))[*7]
        |-> internal_clk == ref_clk_in) else $error("internal clock not reference");
    a_hold_off: assert property ((mode_in == LVL_LOW && bank_disable_inputs[0])[*8]
        |-> !$rose(bank_clk_out[0])) else $error("held bank rose");

    cover property ($rose(lock_out));
    cover property ($fell(lock_out));
    cover property (bank_clk_oe == 2'h0);
endmodule

bind pll_lock_detect_test_mode pll_lock_checker chk_u (
    .clk(clk), .rst(rst), .ref_clk_in(ref_clk_in), .feedback_clock_in(feedback_clock_in),
    .mode_in(mode_in), .bank_disable_inputs(bank_disable_inputs), .lock_out(lock_out),
    .pll_bypass(pll_bypass), .internal_clk(internal_clk), .bank_clk_out(bank_clk_out),
    .bank_clk_oe(bank_clk_oe));

// >>> pll_lock_detect_test_mode_test.sv
`timescale 1ns/100ps
module pll_lock_detect_test_mode_test;
    import clk_supervise_pkg::*;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] data;
        logic err;
    } row_t;
    logic clk, rst, pready, pslverr, irq, e, fb_run, fb_late;
    logic ref_clk_in, feedback_clock_in, pll_clk_in, lock_out, pll_bypass, internal_clk;
    logic [1:0] mode_in, bank_disable_inputs, bank_clk_out, bank_clk_oe;
    logic [31:0] prdata, q;
    apb_req_t apb_req;
    clk_config_t cfg_in;
    int n_mismatch, cmp_count, n;
    row_t rows[7];

    pll_lock_detect_test_mode dut_u (.clk(clk), .rst(rst), .apb_req(apb_req),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .ref_clk_in(ref_clk_in), .feedback_clock_in(feedback_clock_in),
        .pll_clk_in(pll_clk_in), .mode_in(mode_in), .bank_disable_inputs(bank_disable_inputs),
        .cfg_in(cfg_in), .lock_out(lock_out), .pll_bypass(pll_bypass),
        .internal_clk(internal_clk), .bank_clk_out(bank_clk_out), .bank_clk_oe(bank_clk_oe));
    board_clk_model board_u (.clk(clk), .fb_run(fb_run), .fb_late(fb_late),
        .ref_clk_in(ref_clk_in), .feedback_clock_in(feedback_clock_in),
        .pll_clk_in(pll_clk_in));

    // ****
    // Helpers
    // ****
    initial begin
        clk = 1'b0;
        forever begin
            #20 clk = ~clk;
        end
    end
    // Hang guard
    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        conclude();
    end
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_span(input int got, input int lo, input int hi);
        cmp_count++;
        if (got < lo || got > hi) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h to %h", $time, got, lo, hi);
        end
    endtask
    // One APB transfer, held until pready
    task automatic apb_xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        int k;
        @(posedge clk);
        apb_req <= '{a, 1'b1, 1'b0, w, d};
        @(posedge clk);
        apb_req.penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        q = prdata;
        e = pslverr;
        apb_req <= '{a, 1'b0, 1'b0, w, d};
        if (k >= 20) begin
            n_mismatch++;
            conclude();
        end
    endtask
    task automatic wait_for(input int sel, input int lim);
        n = 0;
        while (!(sel == 2 ? feedback_clock_in === 1'b1 : lock_out === (sel == 0)) && n < lim) begin
            @(posedge clk);
            n++;
        end
        if (n >= lim) begin
            n_mismatch++;
            conclude();
        end
    endtask

    // ****
    // Main sequence
    // ****
    initial begin
        rst = 1'b1;
        apb_req = '0;
        mode_in = LVL_LOW;
        bank_disable_inputs = 2'h0;
        cfg_in = '{2'h1, 4'h0, 4'h1, 4'h2, 4'h3};
        fb_run = 1'b0;
        fb_late = 1'b0;
        n_mismatch = 0;
        cmp_count = 0;
        rows = '{'{ADDR_CTRL, {31'h0, CTRL_RST}, 1'b0},
            '{ADDR_PHASE_LIMIT, {24'h0, PHASE_LIMIT_CYC}, 1'b0},
            '{ADDR_WDOG_LIMIT, {20'h0, REF_DIV_RST, WDOG_LIMIT_RST}, 1'b0},
            '{ADDR_STATUS, 32'h0, 1'b0}, '{ADDR_IRQ_STAT, 32'h0, 1'b0},
            '{ADDR_IRQ_MASK, 32'h0, 1'b0}, '{8'h18, 32'h0, 1'b1}};
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            apb_xfer(rows[i].addr, 1'b0, 32'h0);
            chk_word(q, rows[i].data);
            chk_word({31'h0, e}, {31'h0, rows[i].err});
        end
        // Acquisition timed from the first feedback edge
        fb_run <= 1'b1;
        wait_for(2, 100);
        wait_for(0, 700);
        chk_span(n, 494, 510);
        apb_xfer(ADDR_IRQ_STAT, 1'b0, 32'h0);
        chk_word(q & 32'h1, 32'h1);
        chk_word({31'h0, irq}, 32'h0);
        apb_xfer(ADDR_IRQ_MASK, 1'b1, 32'h1);
        @(posedge clk);
        chk_word({31'h0, irq}, 32'h1);
        apb_xfer(ADDR_IRQ_STAT, 1'b1, 32'h1);
        @(posedge clk);
        chk_word({31'h0, irq}, 32'h0);
        // Second reset while locked
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk_word({31'h0, lock_out}, 32'h0);
        wait_for(0, 700);
        // Late feedback: fourth error edge drops lock
        fb_late <= 1'b1;
        wait_for(1, 200);
        chk_span(n, 60, 82);
        apb_xfer(ADDR_IRQ_STAT, 1'b0, 32'h0);
        chk_word(q & 32'h2, 32'h2);
        fb_late <= 1'b0;
        wait_for(0, 700);
        // Short watchdog
        apb_xfer(ADDR_WDOG_LIMIT, 1'b1, 32'h102);
        fb_run <= 1'b0;
        wait_for(1, 300);
        chk_span(n, 20, 150);
        apb_xfer(ADDR_IRQ_STAT, 1'b0, 32'h0);
        chk_word(q & 32'h4, 32'h4);
        // Test mode ignores bank one disable; then test reset
        fb_run <= 1'b1;
        mode_in <= LVL_MID;
        bank_disable_inputs <= 2'h1;
        repeat (10) @(posedge clk);
        chk_word({31'h0, pll_bypass}, 32'h1);
        chk_word({30'h0, bank_clk_oe}, 32'h3);
        bank_disable_inputs <= 2'h3;
        repeat (8) @(posedge clk);
        chk_word({30'h0, bank_clk_oe}, 32'h0);
        repeat (30) @(posedge clk);
        apb_xfer(ADDR_STATUS, 1'b0, 32'h0);
        chk_word(q & 32'hA, 32'h2);
        repeat (70) @(posedge clk);
        apb_xfer(ADDR_STATUS, 1'b0, 32'h0);
        chk_word(q & 32'hA, 32'hA);
        chk_word({28'h0, bank_clk_out, bank_clk_oe}, 32'h0);
        chk_word({31'h0, lock_out}, 32'h0);
        bank_disable_inputs <= 2'h1;
        repeat (8) @(posedge clk);
        chk_word({30'h0, bank_clk_oe}, 32'h3);
        // Hold-off: bank one parks low, bank two keeps toggling
        mode_in <= LVL_LOW;
        repeat (110) @(posedge clk);
        q = 32'h0;
        repeat (48) begin
            @(posedge clk);
            q = q | {30'h0, bank_clk_out};
        end
        chk_word(q, 32'h2);
        conclude();
    end
endmodule
